/* coef_store.sv */
`timescale 1ns/1ps
module coef_store #(
	parameter bit VOLUME_PART = 1'b0 // 0: prototype defaults, 1: volume defaults
) (
	input  wire logic                                      mclk,                // 250 MHz clock
	input  wire logic                                      rst_n,               // async reset
	input  wire logic                                      wr_en,               // word write strobe
	input  wire logic                                      rd_en,               // word read strobe
	input  wire logic [coef_store_pkg::ADDR_W-1:0]         addr,                // word address
	input  wire logic [coef_store_pkg::WORD_W-1:0]         wdata,               // write data
	output logic      [coef_store_pkg::WORD_W-1:0]         rdata,               // read data
	output logic                                           rd_valid,            // read data pulse
	output logic                                           addr_err,            // unmapped access pulse
	output logic signed [coef_store_pkg::COEF_W-1:0]       bridge_offset_coef,  // offset
	output logic signed [coef_store_pkg::COEF_W-1:0]       bridge_gain_coef,    // gain
	output logic signed [coef_store_pkg::COEF_W-1:0]       gain_temp_coef,      // gain drift
	output logic signed [coef_store_pkg::COEF_W-1:0]       offset_temp_coef,    // offset drift
	output logic signed [coef_store_pkg::COEF_W-1:0]       offset_temp_sq_coef, // 2nd order offset
	output logic signed [coef_store_pkg::COEF_W-1:0]       gain_temp_sq_coef,   // 2nd order gain
	output logic signed [coef_store_pkg::COEF_W-1:0]       bridge_sq_coef,      // 2nd order bridge
	output logic      [2:0]                                offset_window,       // window step 0..7
	output logic                                           offset_window_exact  // on a 1000 hex step
);

	// ----------------------------------------------------------------
	// default image: slot 0 flags, slots 1..7 coefficient low words
	// ----------------------------------------------------------------
	localparam logic [15:0] OFFSET_DEF = VOLUME_PART ? coef_store_pkg::OFFSET_VOLUME
	                                                 : coef_store_pkg::OFFSET_PROTO;
	localparam logic [15:0] GAIN_DEF   = VOLUME_PART ? coef_store_pkg::GAIN_VOLUME
	                                                 : coef_store_pkg::GAIN_PROTO;
	localparam logic [coef_store_pkg::SLOTS*coef_store_pkg::WORD_W-1:0] RESET_IMAGE = {
		{5{coef_store_pkg::COEF_RESET}}, GAIN_DEF, OFFSET_DEF, coef_store_pkg::FLAG_RESET};

	coef_store_if bus ();

	logic [3:0]                               wdec;
	logic [3:0]                               rdec;
	logic                                     rd_valid_q;
	logic                                     rd_valid_d;
	logic                                     addr_err_q;
	logic                                     addr_err_d;
	logic [coef_store_pkg::MAG_W-1:0]         mag [coef_store_pkg::NCOEF];
	logic                                     neg [coef_store_pkg::NCOEF];
	logic signed [coef_store_pkg::COEF_W-1:0] coef_d [coef_store_pkg::NCOEF];
	logic signed [coef_store_pkg::COEF_W-1:0] coef_q [coef_store_pkg::NCOEF];
	logic [2:0]                               win_d;
	logic [2:0]                               win_q;
	logic                                     exact_d;
	logic                                     exact_q;
	logic                                     offset_temp_sq_negative;
	logic                                     gain_temp_sq_negative;
	logic                                     bridge_sq_negative;
	logic [coef_store_pkg::WORD_W-1:0]        flags;

	// ----------------------------------------------------------------
	// word access: inputs come from the host decoder on this clock
	// ----------------------------------------------------------------
	assign wdec      = coef_store_pkg::slot_of(addr);
	assign rdec      = coef_store_pkg::slot_of(addr);
	assign bus.wr    = wr_en && wdec[3]; // writes to unmapped words are dropped
	assign bus.wslot = wdec[2:0];
	assign bus.wdata = wdata;
	assign bus.rd    = rd_en;
	assign bus.rzero = !rdec[3]; // unmapped words read as zero
	assign bus.rslot = rdec[2:0];

	coef_mem #(
		.RESET_WORDS (RESET_IMAGE)
	) u_mem (
		.mclk  (mclk),
		.rst_n (rst_n),
		.bus   (bus.store)
	);

	// read answer and error strobe, one cycle after the request
	always_comb begin
		rd_valid_d = rd_en;
		addr_err_d = (rd_en || wr_en) && !wdec[3];
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rd_valid_q <= 1'b0;
			addr_err_q <= 1'b0;
		end else begin
			rd_valid_q <= rd_valid_d;
			addr_err_q <= addr_err_d;
		end
	end

	// ----------------------------------------------------------------
	// coefficient assembly from low word plus flag pair
	// ----------------------------------------------------------------
	assign flags = bus.words[0];

	for (genvar k = 0; k < coef_store_pkg::NCOEF; k++) begin : g_coef
		// coefficient k: bit 16 at flag 2k, sign at flag 2k+1
		assign mag[k] = {flags[coef_store_pkg::FLAG_STRIDE*k + coef_store_pkg::FLAG_MSB_OFS],
		                 bus.words[k+1]};
		assign neg[k] = flags[coef_store_pkg::FLAG_STRIDE*k + coef_store_pkg::FLAG_SIGN_OFS];
	end

	// signed form is what the correction arithmetic consumes
	always_comb begin
		for (int k = 0; k < coef_store_pkg::NCOEF; k++) begin
			coef_d[k] = coef_store_pkg::sm_to_signed(mag[k], neg[k]);
		end
	end

	// registered every cycle with no gating, so a half-written pair reaches the arithmetic one edge later
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			for (int k = 0; k < coef_store_pkg::NCOEF; k++) begin
				coef_q[k] <= '0;
			end
		end else begin
			coef_q <= coef_d;
		end
	end

	// ----------------------------------------------------------------
	// offset window selection
	// ----------------------------------------------------------------
	// step 7 is -1/16..15/16, step 0 is -8/16..8/16; other codes flag inexact
	always_comb begin
		win_d   = bus.words[1][coef_store_pkg::WIN_MSB:coef_store_pkg::WIN_LSB];
		exact_d = !bus.words[1][coef_store_pkg::WIN_SEL_MSB]
		          && (bus.words[1][coef_store_pkg::WIN_LSB-1:0] == '0);
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			win_q   <= 3'h0;
			exact_q <= 1'b0;
		end else begin
			win_q   <= win_d;
			exact_q <= exact_d;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign rdata                   = bus.rdata;
	assign rd_valid                = rd_valid_q;
	assign addr_err                = addr_err_q;
	assign bridge_offset_coef      = coef_q[0];
	assign bridge_gain_coef        = coef_q[1];
	assign gain_temp_coef          = coef_q[2];
	assign offset_temp_coef        = coef_q[3];
	assign offset_temp_sq_coef     = coef_q[4];
	assign gain_temp_sq_coef       = coef_q[5];
	assign bridge_sq_coef          = coef_q[6];
	assign offset_window           = win_q;
	assign offset_window_exact     = exact_q;
	assign offset_temp_sq_negative = neg[4];
	assign gain_temp_sq_negative   = neg[5];
	assign bridge_sq_negative      = neg[6];

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	logic init_seen_q;
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			init_seen_q <= 1'b0;
		end else begin
			init_seen_q <= 1'b1;
		end
	end

	sequence s_offset_write;
		wr_en && addr == coef_store_pkg::BRIDGE_OFFSET_ADDR;
	endsequence

	property p_offset_pair;
		@(posedge mclk) disable iff (!rst_n)
		s_offset_write ##1 !flags[1] |=>
			bridge_offset_coef == $signed({1'b0, $past(flags[0]), $past(wdata, 2)});
	endproperty
	a_offset_pair: assert property (p_offset_pair) else $error("offset low word or bit 16 misplaced");

	// the release edge still shows the reset window, so wait until init is seen
	property p_window;
		@(posedge mclk) disable iff (!rst_n)
		init_seen_q && bus.words[1] == coef_store_pkg::WIN_TOP
		|=> offset_window == coef_store_pkg::WIN_TOP_IDX && offset_window_exact;
	endproperty
	a_window: assert property (p_window) else $error("offset window step wrong");

	property p_defaults;
		@(posedge mclk) disable iff (!rst_n)
		!init_seen_q |-> bus.words[1] == OFFSET_DEF && bus.words[2] == GAIN_DEF;
	endproperty
	a_defaults: assert property (p_defaults) else $error("reset default word wrong");

	property p_gain_neg;
		@(posedge mclk) disable iff (!rst_n)
		flags[3] |=> bridge_gain_coef == -$signed({1'b0, $past(flags[2]), $past(bus.words[2])});
	endproperty
	a_gain_neg: assert property (p_gain_neg) else $error("gain sign or bit 16 wrong");

	property p_gain_temp;
		@(posedge mclk) disable iff (!rst_n)
		!flags[5] |=> gain_temp_coef[16:0] == $past({flags[4], bus.words[3]}) && !gain_temp_coef[17];
	endproperty
	a_gain_temp: assert property (p_gain_temp) else $error("gain drift term wrong");

	property p_offset_temp;
		@(posedge mclk) disable iff (!rst_n)
		flags[7] && bus.words[4] != '0 |=> offset_temp_coef < 0;
	endproperty
	a_offset_temp: assert property (p_offset_temp) else $error("offset drift sign wrong");

	property p_sq_terms;
		@(posedge mclk) disable iff (!rst_n)
		!offset_temp_sq_negative && !gain_temp_sq_negative && !bridge_sq_negative |=>
			offset_temp_sq_coef == $signed({1'b0, $past(flags[8]), $past(bus.words[5])})
			&& gain_temp_sq_coef == $signed({1'b0, $past(flags[10]), $past(bus.words[6])})
			&& bridge_sq_coef == $signed({1'b0, $past(flags[12]), $past(bus.words[7])});
	endproperty
	a_sq_terms: assert property (p_sq_terms) else $error("second order term wrong");

	property p_sign_sense;
		@(posedge mclk) disable iff (!rst_n)
		bus.words[1] != '0 |=> bridge_offset_coef[17] == $past(flags[1]);
	endproperty
	a_sign_sense: assert property (p_sign_sense) else $error("sign sense inverted");

	property p_read_back;
		@(posedge mclk) disable iff (!rst_n)
		rd_en && addr == coef_store_pkg::BRIDGE_GAIN_ADDR |=> rd_valid
			&& rdata == $past(bus.words[2]);
	endproperty
	a_read_back: assert property (p_read_back) else $error("read data wrong");

	// helper for the refused-access checks: any word outside 03 and 05..0b
	logic addr_hole;
	assign addr_hole = addr != coef_store_pkg::FLAG_ADDR
	                   && (addr < coef_store_pkg::BRIDGE_OFFSET_ADDR
	                   || addr > coef_store_pkg::BRIDGE_SQ_ADDR);

	sequence s_gain_write;
		wr_en && addr == coef_store_pkg::BRIDGE_GAIN_ADDR;
	endsequence

	sequence s_flag_write;
		wr_en && addr == coef_store_pkg::FLAG_ADDR;
	endsequence

	property p_gain_store;
		@(posedge mclk) disable iff (!rst_n)
		s_gain_write |=> bus.words[2] == $past(wdata);
	endproperty
	a_gain_store: assert property (p_gain_store) else $error("gain low word not stored");

	property p_flag_store;
		@(posedge mclk) disable iff (!rst_n)
		s_flag_write |=> flags == $past(wdata);
	endproperty
	a_flag_store: assert property (p_flag_store) else $error("flag word not stored");

	// write, then the pair assembled one edge later while the sign stays clear
	property p_gain_pair;
		@(posedge mclk) disable iff (!rst_n)
		s_gain_write ##1 !flags[3] |=>
			bridge_gain_coef == $signed({1'b0, $past(flags[2]), $past(wdata, 2)});
	endproperty
	a_gain_pair: assert property (p_gain_pair) else $error("gain pair misassembled");

	property p_window_low;
		@(posedge mclk) disable iff (!rst_n)
		init_seen_q && bus.words[1] == '0 |=> offset_window == '0 && offset_window_exact;
	endproperty
	a_window_low: assert property (p_window_low) else $error("window step 0 wrong");

	property p_win_inexact;
		@(posedge mclk) disable iff (!rst_n)
		bus.words[1][coef_store_pkg::WIN_LSB-1:0] != '0 |=> !offset_window_exact;
	endproperty
	a_win_inexact: assert property (p_win_inexact) else $error("off-step marked exact");

	property p_osq_neg;
		@(posedge mclk) disable iff (!rst_n)
		offset_temp_sq_negative && bus.words[5] != '0 |=> offset_temp_sq_coef < 0;
	endproperty
	a_osq_neg: assert property (p_osq_neg) else $error("offset square sign wrong");

	property p_gsq_neg;
		@(posedge mclk) disable iff (!rst_n)
		gain_temp_sq_negative && bus.words[6] != '0 |=> gain_temp_sq_coef < 0;
	endproperty
	a_gsq_neg: assert property (p_gsq_neg) else $error("gain square sign wrong");

	property p_bsq_neg;
		@(posedge mclk) disable iff (!rst_n)
		bridge_sq_negative && bus.words[7] != '0 |=> bridge_sq_coef < 0;
	endproperty
	a_bsq_neg: assert property (p_bsq_neg) else $error("bridge square sign wrong");

	// a set sign on a zero magnitude must still give zero, not a stray value
	property p_neg_zero;
		@(posedge mclk) disable iff (!rst_n)
		flags[1] && !flags[0] && bus.words[1] == '0 |=> bridge_offset_coef == '0;
	endproperty
	a_neg_zero: assert property (p_neg_zero) else $error("negative zero not zero");

	property p_read_pulse;
		@(posedge mclk) disable iff (!rst_n)
		rd_en |=> rd_valid;
	endproperty
	a_read_pulse: assert property (p_read_pulse) else $error("read answer missing");

	property p_refused;
		@(posedge mclk) disable iff (!rst_n)
		(wr_en || rd_en) && addr_hole |=> addr_err;
	endproperty
	a_refused: assert property (p_refused) else $error("unmapped access not flagged");

endmodule

/* coef_store_pkg.sv */
package coef_store_pkg;

	// ----------------------------------------------------------------
	// widths
	// ----------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam int WORD_W = 16;
	localparam int SLOTS  = 8;
	localparam int SLOT_W = 3;
	localparam int NCOEF  = 7;
	localparam int MAG_W  = 17;
	localparam int COEF_W = 18;

	// ----------------------------------------------------------------
	// word addresses of the calibration store
	// ----------------------------------------------------------------
	localparam logic [7:0] FLAG_ADDR          = 8'h03;
	localparam logic [7:0] BRIDGE_OFFSET_ADDR = 8'h05;
	localparam logic [7:0] BRIDGE_GAIN_ADDR   = 8'h06;
	localparam logic [7:0] GAIN_TEMP_ADDR     = 8'h07;
	localparam logic [7:0] OFFSET_TEMP_ADDR   = 8'h08;
	localparam logic [7:0] OFFSET_TEMP_SQ_ADDR = 8'h09;
	localparam logic [7:0] GAIN_TEMP_SQ_ADDR  = 8'h0a;
	localparam logic [7:0] BRIDGE_SQ_ADDR     = 8'h0b;

	// ----------------------------------------------------------------
	// flag word layout: coefficient k owns bits 2k (bit 16) and 2k+1 (sign)
	// ----------------------------------------------------------------
	localparam int FLAG_MSB_OFS  = 0;
	localparam int FLAG_SIGN_OFS = 1;
	localparam int FLAG_STRIDE   = 2;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [15:0] FLAG_RESET    = 16'h0000;
	localparam logic [15:0] COEF_RESET    = 16'h0000;
	localparam logic [15:0] OFFSET_PROTO  = 16'h0000;
	localparam logic [15:0] OFFSET_VOLUME = 16'h7000;
	localparam logic [15:0] GAIN_PROTO    = 16'h0000;
	localparam logic [15:0] GAIN_VOLUME   = 16'h8000;

	// ----------------------------------------------------------------
	// offset window: one step of 1/16 per 1000 hex
	// ----------------------------------------------------------------
	localparam int          WIN_MSB     = 14;
	localparam int          WIN_LSB     = 12;
	localparam int          WIN_SEL_MSB = 15;
	localparam logic [15:0] WIN_STEP    = 16'h1000;
	localparam logic [15:0] WIN_TOP     = 16'h7000;
	localparam logic [2:0]  WIN_TOP_IDX = 3'h7;

	// address decode shared by the write and the read path: {hit, slot}
	function automatic logic [3:0] slot_of(logic [7:0] a);
		case (a)
			FLAG_ADDR:           return 4'h8;
			BRIDGE_OFFSET_ADDR:  return 4'h9;
			BRIDGE_GAIN_ADDR:    return 4'ha;
			GAIN_TEMP_ADDR:      return 4'hb;
			OFFSET_TEMP_ADDR:    return 4'hc;
			OFFSET_TEMP_SQ_ADDR: return 4'hd;
			GAIN_TEMP_SQ_ADDR:   return 4'he;
			BRIDGE_SQ_ADDR:      return 4'hf;
			default:             return 4'h0;
		endcase
	endfunction

	// sign-magnitude to two's complement; a set sign means negative
	function automatic logic signed [17:0] sm_to_signed(logic [16:0] mag, logic neg);
		logic signed [17:0] v;
		v = $signed({1'b0, mag});
		return neg ? -v : v;
	endfunction

endpackage

/* coef_store_if.sv */
`timescale 1ns/1ps
interface coef_store_if;
	logic                                      wr;     // write strobe
	logic [coef_store_pkg::SLOT_W-1:0]         wslot;  // write slot
	logic [coef_store_pkg::WORD_W-1:0]         wdata;  // write data
	logic                                      rd;     // read strobe
	logic                                      rzero;  // read of an unmapped word
	logic [coef_store_pkg::SLOT_W-1:0]         rslot;  // read slot
	logic [coef_store_pkg::WORD_W-1:0]         rdata;  // registered read data
	logic [coef_store_pkg::WORD_W-1:0]         words [coef_store_pkg::SLOTS];

	modport store (input wr, wslot, wdata, rd, rzero, rslot, output rdata, words);
	modport ctrl  (output wr, wslot, wdata, rd, rzero, rslot, input rdata, words);
endinterface

/* coef_mem.sv */
`timescale 1ns/1ps
module coef_mem #(
	parameter logic [coef_store_pkg::SLOTS*coef_store_pkg::WORD_W-1:0] RESET_WORDS = '0
) (
	input wire logic   mclk,  // system clock
	input wire logic   rst_n, // async reset, active low
	coef_store_if.store bus   // access and word view
);

	logic [coef_store_pkg::WORD_W-1:0] words_q [coef_store_pkg::SLOTS];
	logic [coef_store_pkg::WORD_W-1:0] words_d [coef_store_pkg::SLOTS];
	logic [coef_store_pkg::WORD_W-1:0] rdata_q;
	logic [coef_store_pkg::WORD_W-1:0] rdata_d;

	// ----------------------------------------------------------------
	// next values: write to one slot, read holds until the next read
	// ----------------------------------------------------------------
	always_comb begin
		for (int i = 0; i < coef_store_pkg::SLOTS; i++) begin
			words_d[i] = words_q[i];
		end
		if (bus.wr) begin
			words_d[bus.wslot] = bus.wdata;
		end
		rdata_d = rdata_q;
		if (bus.rd) begin
			rdata_d = bus.rzero ? '0 : words_q[bus.rslot]; // old value on a same-cycle write
		end
	end

	// reset loads the part's default image, a constant per slot
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < coef_store_pkg::SLOTS; i++) begin
				words_q[i] <= RESET_WORDS[i*coef_store_pkg::WORD_W +: coef_store_pkg::WORD_W];
			end
			rdata_q <= '0;
		end else begin
			words_q <= words_d;
			rdata_q <= rdata_d;
		end
	end

	assign bus.words = words_q;
	assign bus.rdata = rdata_q;

endmodule

/* coef_store_tb.sv */
`timescale 1ns/1ps
module testbench;

	// ----------------------------------------------------------------
	// stimulus, design and reference store
	// ----------------------------------------------------------------
	localparam int limit_cycles = 20000;   // whole run is under a thousand cycles
	logic               mclk      = 1'b0;  // 250 MHz
	logic               rst_n     = 1'b0;  // held low from time zero
	logic               wr_en     = 1'b0;
	logic               rd_en     = 1'b0;
	logic [7:0]         addr      = 8'h00;
	logic [15:0]        wdata     = 16'h0000;
	logic [15:0]        rdata;
	logic               rd_valid;
	logic               addr_err;
	logic signed [17:0] coef [7];          // coefficient outputs in address order
	logic [2:0]         offset_window;
	logic               offset_window_exact;
	logic [15:0]        proto_rdata;       // prototype variant outputs
	logic signed [17:0] proto_offset;
	logic signed [17:0] proto_gain;
	logic [2:0]         proto_window;
	logic               proto_exact;
	int                 fails     = 0;
	int                 cmp_count = 0;
	int                 cycles    = 0;
	int                 mw [256];          // expected word per address

	// free-running clock, one inversion per half period
	always #2 mclk = ~mclk;

	coef_store #(.VOLUME_PART(1'b1)) dut (
		.mclk                (mclk),
		.rst_n               (rst_n),
		.wr_en               (wr_en),
		.rd_en               (rd_en),
		.addr                (addr),
		.wdata               (wdata),
		.rdata               (rdata),
		.rd_valid            (rd_valid),
		.addr_err            (addr_err),
		.bridge_offset_coef  (coef[0]),
		.bridge_gain_coef    (coef[1]),
		.gain_temp_coef      (coef[2]),
		.offset_temp_coef    (coef[3]),
		.offset_temp_sq_coef (coef[4]),
		.gain_temp_sq_coef   (coef[5]),
		.bridge_sq_coef      (coef[6]),
		.offset_window       (offset_window),
		.offset_window_exact (offset_window_exact)
	);

	// prototype variant on the same bus, for the other set of defaults
	coef_store #(.VOLUME_PART(1'b0)) dut_proto (
		.mclk                (mclk),
		.rst_n               (rst_n),
		.wr_en               (wr_en),
		.rd_en               (rd_en),
		.addr                (addr),
		.wdata               (wdata),
		.rdata               (proto_rdata),
		.rd_valid            (),
		.addr_err            (),
		.bridge_offset_coef  (proto_offset),
		.bridge_gain_coef    (proto_gain),
		.gain_temp_coef      (),
		.offset_temp_coef    (),
		.offset_temp_sq_coef (),
		.gain_temp_sq_coef   (),
		.bridge_sq_coef      (),
		.offset_window       (proto_window),
		.offset_window_exact (proto_exact)
	);

	// ----------------------------------------------------------------
	// reference model
	// ----------------------------------------------------------------
	function automatic bit mapped(logic [7:0] a);
		return a == 8'h03 || (a >= 8'h05 && a <= 8'h0b);
	endfunction

	// sign-magnitude to two's complement, worked with plain integers
	function automatic logic [17:0] exp_coef(int k);
		int m;
		m = (((mw[3] >> (2 * k)) & 1) << 16) | mw[5 + k];
		if (((mw[3] >> (2 * k + 1)) & 1) == 1) begin
			m = -m;
		end
		return 18'(m);
	endfunction

	// volume-part defaults, since the bench builds the volume variant
	task automatic model_reset;
		foreach (mw[i]) begin
			mw[i] = 0;
		end
		mw[5] = 'h7000;
		mw[6] = 'h8000;
	endtask

	// ----------------------------------------------------------------
	// comparisons and verdict
	// ----------------------------------------------------------------
	task automatic tally(input bit bad, input string what);
		cmp_count++;
		if (bad) begin
			fails++;
			$display("mismatch at %0t: %s", $time, what);
		end
	endtask

	task automatic check_word(input logic [15:0] got, input logic [15:0] exp, input string what);
		tally(got !== exp, $sformatf("%s got %h expected %h", what, got, exp));
	endtask

	task automatic check_coef(input logic [17:0] got, input logic [17:0] exp, input string what);
		tally(got !== exp, $sformatf("%s got %h expected %h", what, got, exp));
	endtask

	task automatic check_bit(input logic got, input logic exp, input string what);
		tally(got !== exp, $sformatf("%s got %b expected %b", what, got, exp));
	endtask

	task automatic print_verdict;
		$display("comparisons %0d, mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// a hang ends the run through the same verdict
	always @(posedge mclk) begin
		cycles++;
		if (cycles == limit_cycles) begin
			fails++;
			$display("mismatch at %0t: run did not finish in time", $time);
			print_verdict;
		end
	end

	// ----------------------------------------------------------------
	// bus cycles
	// ----------------------------------------------------------------
	task automatic settle;
		@(posedge mclk);
		#1;
	endtask

	// strobe low for a cycle between calls, so no signal is driven twice at one edge
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge mclk);
		wr_en <= 1'b1;
		addr  <= a;
		wdata <= d;
		@(posedge mclk);
		wr_en <= 1'b0;
		#1;
		check_bit(addr_err, !mapped(a), "write address error");
		check_bit(rd_valid, 1'b0, "valid on write");
		if (mapped(a)) begin
			mw[a] = int'(d);
		end
	endtask

	task automatic rd(input logic [7:0] a);
		@(posedge mclk);
		rd_en <= 1'b1;
		addr  <= a;
		@(posedge mclk);
		rd_en <= 1'b0;
		#1;
		check_bit(rd_valid, 1'b1, "read valid");
		check_bit(addr_err, !mapped(a), "read address error");
		check_word(rdata, mapped(a) ? 16'(mw[a]) : 16'h0000, "read data");
	endtask

	// coefficients and window against the model, one edge after the last write
	task automatic check_all;
		for (int k = 0; k < 7; k++) begin
			check_coef(coef[k], exp_coef(k), $sformatf("coef %0d", k));
		end
		check_word({13'h0000, offset_window}, 16'((mw[5] >> 12) & 7), "window");
		check_bit(offset_window_exact, (mw[5] & 'h8fff) == 0, "window exact");
	endtask

	// prototype defaults: both low words zero, so window step 0 on an exact step
	task automatic check_proto;
		check_coef(proto_offset, 18'h00000, "prototype offset");
		check_coef(proto_gain, 18'h00000, "prototype gain");
		check_word({13'h0000, proto_window}, 16'h0000, "prototype window");
		check_bit(proto_exact, 1'b1, "prototype exact");
	endtask

	task automatic do_reset;
		@(posedge mclk);
		rst_n <= 1'b0;
		repeat (5) @(posedge mclk);
		#1;
		check_bit(rd_valid, 1'b0, "valid in reset");
		check_coef(coef[1], 18'h00000, "gain in reset");
		@(posedge mclk);
		rst_n <= 1'b1;
		model_reset;
	endtask

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		void'($urandom(29));
		model_reset;
		do_reset;
		settle;
		check_all;
		check_proto;
		for (int a = 0; a < 16; a++) begin
			rd(8'(a));
		end
		// unmapped writes must leave every word alone
		wr(8'h04, 16'hffff);
		wr(8'h0c, 16'h1234);
		wr(8'hff, 16'h5555);
		rd(8'h04);
		rd(8'hff);
		// every window step, then off-step values
		for (int k = 0; k < 8; k++) begin
			wr(8'h05, 16'(k << 12));
			settle;
			check_all;
		end
		wr(8'h05, 16'h7001);
		settle;
		check_all;
		wr(8'h05, 16'h8000);
		settle;
		check_all;
		// a single flag bit walked across distinct low words isolates each position
		for (int k = 0; k < 7; k++) begin
			wr(8'(5 + k), 16'(16'h1111 * (k + 1)));
		end
		for (int b = 0; b < 16; b++) begin
			wr(8'h03, 16'(1 << b));
			settle;
			check_all;
			rd(8'h03);
		end
		// negative zero must read as zero
		wr(8'h05, 16'h0000);
		wr(8'h03, 16'h0002);
		settle;
		check_all;
		// read and write of one word at one edge returns the old word
		@(posedge mclk);
		wr_en <= 1'b1;
		rd_en <= 1'b1;
		addr  <= 8'h07;
		wdata <= 16'hbeef;
		@(posedge mclk);
		wr_en <= 1'b0;
		rd_en <= 1'b0;
		#1;
		check_word(rdata, 16'(mw[7]), "read during write");
		mw[7] = 'hbeef;
		settle;
		check_all;
		// random traffic over mapped and unmapped words, flag word favoured
		for (int i = 0; i < 200; i++) begin
			wr((i % 4 == 0) ? 8'h03 : 8'($urandom_range(0, 15)), 16'($urandom));
			if (i % 4 == 3) begin
				settle;
				check_all;
			end
		end
		for (int a = 0; a < 16; a++) begin
			rd(8'(a));
		end
		// second reset in mid-run restores the defaults
		do_reset;
		settle;
		check_all;
		check_proto;
		rd(8'h05);
		check_word(proto_rdata, 16'h0000, "prototype offset word");
		rd(8'h06);
		check_word(proto_rdata, 16'h0000, "prototype gain word");
		rd(8'h03);
		print_verdict;
	end

endmodule
